//--- dpb_pkg.sv
// Purpose: shared constants and types of the data pre-fetch buffer
// Assumes: one core clock, APB register access with 32-bit data
// Notes:   lines are 128 bytes, tracked as two 64-byte halves
package dpb_pkg;

  localparam int          DPB_ENTRIES    = 8;
  localparam int          DPB_IDX_W      = 3;
  localparam int          DPB_GEN_W      = 4;
  localparam int          DPB_TAG_W      = DPB_IDX_W + 1 + DPB_GEN_W;
  localparam int          DPB_HALF_SHIFT = 6;
  localparam int          DPB_LINE_BYTES = 128;
  localparam int          DPB_HALF_BYTES = DPB_LINE_BYTES / 2;
  localparam int          DPB_GRAN_W     = 32 - DPB_HALF_SHIFT;
  localparam int          DPB_WORD_W     = 32;

  // register byte offsets
  localparam logic [11:0] DPB_REG_CTRL   = 12'h000;
  localparam logic [11:0] DPB_REG_STAT   = 12'h004;
  localparam logic [11:0] DPB_REG_MASK   = 12'h008;
  localparam logic [11:0] DPB_REG_STATE  = 12'h00C;

  // control fields
  localparam int          DPB_CTRL_W     = 2;
  localparam int          DPB_CTRL_EN    = 0;
  localparam int          DPB_CTRL_RF    = 1;
  localparam logic [1:0]  DPB_CTRL_RST   = 2'h3;

  // event / status bits
  localparam int          DPB_EV_W       = 6;
  localparam int          DPB_EV_DHIT    = 0;
  localparam int          DPB_EV_DWAIT   = 1;
  localparam int          DPB_EV_AHIT    = 2;
  localparam int          DPB_EV_MISS    = 3;
  localparam int          DPB_EV_STALE   = 4;
  localparam int          DPB_EV_FAIL    = 5;
  localparam logic [5:0]  DPB_MASK_RST   = 6'h00;

  // state register fields
  localparam int          DPB_ST_PTR_LSB = 8;
  localparam int          DPB_ST_FSM_LSB = 12;

  typedef enum logic [2:0] {
    DPB_KIND_DHIT   = 3'h0,
    DPB_KIND_DWAIT  = 3'h1,
    DPB_KIND_AHIT   = 3'h2,
    DPB_KIND_MISS   = 3'h3,
    DPB_KIND_BYPASS = 3'h4
  } dpb_kind_t;

  typedef enum logic [1:0] {
    DPB_ST_IDLE = 2'b00,
    DPB_ST_WAIT = 2'b01,
    DPB_ST_FWD  = 2'b11
  } dpb_state_t;

endpackage

//--- dpb_prefetch_buffer.sv
// Purpose: data pre-fetch buffer of the extended_memory_controller
// Assumes: one access outstanding at a time; prefetch returns carry the issued tag
// Notes:   line payload is carried as one 32-bit word per 64-byte half
// Contract
// RL1 - data present: serve from buffer
// RL2 - prefetch outstanding: hold, serve on return
// RL3 - no data, nothing pending: forward
// RL4 - miss forwards; candidate hit allocates stream
// RL5 - colliding prefetches: later one wins
// RL6 - controller drops oldest prefetch when full
// RL7 - writes invalidate matching prefetched data
// RL8 - failed return leaves entry without data
// RL9 - 128-byte lines as two 64-byte halves
// RL10 - level-2 consumes whole line, level-1 half
// RL11 - level-1 hit re-fetches other half
// RL12 - re-fetch only for level-1 accesses
// RL13 - re-allocation makes older prefetch stale
// RL14 - eight entries, oldest replaced by pointer
// RL15 - allocation fetches X+64 then X+128
// RL16 - prefetch only if cacheable and prefetchable
// RL17 - level-2 frozen/disabled: treat as level-1
// RL18 - per half: present, pending, request tag
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module dpb_prefetch_buffer
  import dpb_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata_q,
  output logic                      pready_q,
  output logic                      pslverr_q,
  output logic                      irq_q,
  input  wire logic                 acc_valid,
  input  wire logic [31:0]          acc_addr,
  input  wire logic                 acc_write,
  input  wire logic                 acc_src_l2,
  input  wire logic                 region_cacheable_bit,
  input  wire logic                 region_prefetchable_bit,
  input  wire logic                 level2_freeze_bit,
  input  wire logic [2:0]           level2_size_mode,
  output logic                      acc_ready_q,
  output logic                      resp_valid_q,
  output dpb_kind_t                 resp_kind_q,
  output logic      [63:0]          resp_data_q,
  output logic                      fwd_valid_q,
  output logic      [31:0]          fwd_addr_q,
  output logic                      fwd_write_q,
  input  wire logic                 fwd_ready,
  output logic                      pf_valid_q,
  output logic      [31:0]          pf_addr_q,
  output logic      [DPB_TAG_W-1:0] pf_tag_q,
  input  wire logic                 pf_ready,
  input  wire logic                 ret_valid,
  input  wire logic [DPB_TAG_W-1:0] ret_tag,
  input  wire logic                 ret_ok,
  input  wire logic [31:0]          ret_data
);

  // returns {hit, half}: the entry covers granule base and base+1
  function automatic logic [1:0] half_hit(input logic [DPB_GRAN_W-1:0] base,
                                          input logic [DPB_GRAN_W-1:0] gran);
    logic [DPB_GRAN_W-1:0] nxt;
    nxt = base + 26'h1;
    half_hit = {(gran == base) || (gran == nxt), gran == nxt};
  endfunction

  logic [DPB_GRAN_W-1:0] ent_base_q [DPB_ENTRIES];
  logic [DPB_ENTRIES-1:0] ent_vld_q;
  logic [1:0]            ent_pres_q [DPB_ENTRIES];
  logic [1:0]            ent_pend_q [DPB_ENTRIES];
  logic [DPB_GEN_W-1:0]  ent_gen_q  [DPB_ENTRIES][2];
  logic [DPB_WORD_W-1:0] ent_data_q [DPB_ENTRIES][2];
  logic [DPB_IDX_W-1:0]  alloc_ptr_q;
  logic [DPB_GEN_W-1:0]  gen_q;
  logic [DPB_GRAN_W-1:0] cand_q;
  logic                  cand_vld_q;
  dpb_state_t            state_q;
  logic [DPB_IDX_W-1:0]  hold_idx_q;
  logic [DPB_GRAN_W-1:0] hold_base_q;
  logic [1:0]            hold_need_q;
  logic                  hold_half_q;
  logic                  hold_l1_q;
  logic [31:0]           hold_addr_q;
  logic                  sched_q;
  logic [31:0]           sched_addr_q;
  logic [DPB_TAG_W-1:0]  sched_tag_q;
  logic [DPB_CTRL_W-1:0] ctrl_q;
  logic [DPB_EV_W-1:0]   stat_q;
  logic [DPB_EV_W-1:0]   mask_q;

  logic [DPB_GRAN_W-1:0] gran;
  logic                  hit_any;
  logic [DPB_IDX_W-1:0]  hit_idx;
  logic                  hit_half;
  logic [1:0]            need;
  logic [1:0]            cand_hh;
  dpb_kind_t             kind;
  logic                  take, pf_ok, is_l1, cls;
  logic                  alloc, refetch, new_pf_v;
  logic [31:0]           new_addr;
  logic [DPB_TAG_W-1:0]  new_tag;
  logic                  drop_a_v, drop_b_v;
  logic [DPB_IDX_W-1:0]  ret_slot;
  logic                  ret_half;
  logic                  ret_live;
  logic                  w_serve, w_give;
  logic [DPB_EV_W-1:0]   ev;
  logic                  apb_acc, mapped, wr_en;
  logic [31:0]           rd_mux;

  assign take     = acc_valid & acc_ready_q;
  assign pf_ok    = region_cacheable_bit & region_prefetchable_bit & ctrl_q[DPB_CTRL_EN]; // RL16
  assign is_l1    = ~acc_src_l2 | level2_freeze_bit | (level2_size_mode == 3'h0); // RL17
  assign cls      = take & ~acc_write & pf_ok;
  assign ret_slot = ret_tag[DPB_TAG_W-1 -: DPB_IDX_W];
  assign ret_half = ret_tag[DPB_GEN_W];
  assign ret_live = ent_vld_q[ret_slot] & ent_pend_q[ret_slot][ret_half]
                  & (ent_gen_q[ret_slot][ret_half] == ret_tag[DPB_GEN_W-1:0]); // RL13

  // lookup and classification of the offered access
  always_comb
  begin
    gran     = acc_addr[31:DPB_HALF_SHIFT]; // RL9
    hit_any  = 1'b0;
    hit_idx  = '0;
    hit_half = 1'b0;
    for (int i = 0; i < DPB_ENTRIES; i++)
    begin
      if (ent_vld_q[i] && half_hit(ent_base_q[i], gran) == 2'b10 && !hit_any)
      begin
        hit_any  = 1'b1;
        hit_idx  = DPB_IDX_W'(i);
        hit_half = 1'b0;
      end
      else if (ent_vld_q[i] && half_hit(ent_base_q[i], gran) == 2'b11 && !hit_any)
      begin
        hit_any  = 1'b1;
        hit_idx  = DPB_IDX_W'(i);
        hit_half = 1'b1;
      end
    end
    need = is_l1 ? (hit_half ? 2'b10 : 2'b01) : 2'b11; // RL10
    if (!hit_any)
      kind = DPB_KIND_MISS; // RL4
    else if ((ent_pres_q[hit_idx] & need) == need)
      kind = DPB_KIND_DHIT; // RL1
    else if (|(ent_pend_q[hit_idx] & need))
      kind = DPB_KIND_DWAIT; // RL2
    else
      kind = DPB_KIND_AHIT; // RL3
  end

  // new streams come only from a candidate hit; the candidate is the last missed granule
  assign cand_hh = half_hit(cand_q, gran);
  assign alloc   = cls & ~hit_any & cand_vld_q & cand_hh[1]; // RL4
  assign refetch = cls & hit_any & is_l1 & ctrl_q[DPB_CTRL_RF]
                 & ~ent_pres_q[hit_idx][~hit_half] & ~ent_pend_q[hit_idx][~hit_half]; // RL11 RL12
  assign new_pf_v = alloc | refetch;

  always_comb
  begin
    if (alloc)
    begin
      new_addr = {gran + 26'h1, 6'h00}; // RL15
      new_tag  = {alloc_ptr_q, 1'b0, gen_q};
    end
    else
    begin
      new_addr = {ent_base_q[hit_idx] + {25'h0, ~hit_half}, 6'h00}; // RL11
      new_tag  = {hit_idx, ~hit_half, gen_q};
    end
  end

  // an unaccepted prefetch is discarded when a newer one arrives
  assign drop_a_v = pf_valid_q & ~pf_ready & (new_pf_v | sched_q); // RL5
  assign drop_b_v = sched_q & new_pf_v; // RL5

  // waiting access: serve once data lands, fall back if the prefetch vanished
  assign w_serve = (state_q == DPB_ST_WAIT) && (ent_base_q[hold_idx_q] == hold_base_q)
                 && ((ent_pres_q[hold_idx_q] & hold_need_q) == hold_need_q); // RL2
  assign w_give  = (state_q == DPB_ST_WAIT) && !w_serve
                 && ((ent_base_q[hold_idx_q] != hold_base_q)
                     || !(|(ent_pend_q[hold_idx_q] & hold_need_q)));

  always_comb
  begin
    ev               = '0;
    ev[DPB_EV_DHIT]  = (cls && kind == DPB_KIND_DHIT) || w_serve;
    ev[DPB_EV_DWAIT] = cls && kind == DPB_KIND_DWAIT;
    ev[DPB_EV_AHIT]  = (cls && kind == DPB_KIND_AHIT) || w_give;
    ev[DPB_EV_MISS]  = cls && kind == DPB_KIND_MISS;
    ev[DPB_EV_STALE] = (ret_valid && !ret_live) || drop_a_v || drop_b_v;
    ev[DPB_EV_FAIL]  = ret_valid && ret_live && !ret_ok;
  end

  // entry table: later statements win, so allocation overrides older updates
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ent_vld_q   <= '0;
      alloc_ptr_q <= '0;
      gen_q       <= '0;
      cand_q      <= '0;
      cand_vld_q  <= 1'b0;
      for (int i = 0; i < DPB_ENTRIES; i++)
      begin
        ent_base_q[i]    <= '0;
        ent_pres_q[i]    <= 2'h0;
        ent_pend_q[i]    <= 2'h0;
        ent_gen_q[i][0]  <= '0;
        ent_gen_q[i][1]  <= '0;
        ent_data_q[i][0] <= '0;
        ent_data_q[i][1] <= '0;
      end
    end
    else
    begin
      if (ret_valid && ret_live)
      begin
        ent_pend_q[ret_slot][ret_half] <= 1'b0;
        if (ret_ok)
        begin
          ent_pres_q[ret_slot][ret_half] <= 1'b1;
          ent_data_q[ret_slot][ret_half] <= ret_data;
        end // RL8
      end
      if (drop_a_v && ent_gen_q[pf_tag_q[7:5]][pf_tag_q[4]] == pf_tag_q[3:0])
        ent_pend_q[pf_tag_q[7:5]][pf_tag_q[4]] <= 1'b0; // RL5
      if (drop_b_v && ent_gen_q[sched_tag_q[7:5]][sched_tag_q[4]] == sched_tag_q[3:0])
        ent_pend_q[sched_tag_q[7:5]][sched_tag_q[4]] <= 1'b0; // RL5
      if (take && acc_write && hit_any)
      begin
        ent_pres_q[hit_idx][hit_half] <= 1'b0; // RL7
        ent_pend_q[hit_idx][hit_half] <= 1'b0; // RL7
      end
      if (cls && !hit_any)
      begin
        cand_q     <= gran;
        cand_vld_q <= ~alloc;
      end
      if (alloc)
      begin
        ent_vld_q[alloc_ptr_q]     <= 1'b1;
        ent_base_q[alloc_ptr_q]    <= gran + 26'h1;
        ent_pres_q[alloc_ptr_q]    <= 2'h0;
        ent_pend_q[alloc_ptr_q]    <= 2'h3; // RL18
        ent_gen_q[alloc_ptr_q][0]  <= gen_q; // RL13
        ent_gen_q[alloc_ptr_q][1]  <= gen_q + 4'h1; // RL13
        alloc_ptr_q                <= alloc_ptr_q + 3'h1; // RL14
        gen_q                      <= gen_q + 4'h2;
      end
      else if (refetch)
      begin
        ent_pend_q[hit_idx][~hit_half] <= 1'b1; // RL11
        ent_gen_q[hit_idx][~hit_half]  <= gen_q; // RL18
        gen_q                          <= gen_q + 4'h1;
      end
    end
  end

  // prefetch issue port; the second half of a new stream goes one cycle later
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pf_valid_q   <= 1'b0;
      pf_addr_q    <= '0;
      pf_tag_q     <= '0;
      sched_q      <= 1'b0;
      sched_addr_q <= '0;
      sched_tag_q  <= '0;
    end
    else
    begin
      if (new_pf_v)
      begin
        pf_valid_q <= 1'b1;
        pf_addr_q  <= new_addr;
        pf_tag_q   <= new_tag;
      end
      else if (sched_q)
      begin
        pf_valid_q <= 1'b1;
        pf_addr_q  <= sched_addr_q;
        pf_tag_q   <= sched_tag_q;
      end
      else if (pf_ready)
        pf_valid_q <= 1'b0;
      sched_q <= alloc;
      if (alloc)
      begin
        sched_addr_q <= {gran + 26'h2, 6'h00}; // RL15
        sched_tag_q  <= {alloc_ptr_q, 1'b1, gen_q + 4'h1};
      end
    end
  end

  // access sequencing, response and forwarding
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= DPB_ST_IDLE;
      acc_ready_q  <= 1'b1;
      resp_valid_q <= 1'b0;
      resp_kind_q  <= DPB_KIND_BYPASS;
      resp_data_q  <= '0;
      fwd_valid_q  <= 1'b0;
      fwd_addr_q   <= '0;
      fwd_write_q  <= 1'b0;
      hold_idx_q   <= '0;
      hold_base_q  <= '0;
      hold_need_q  <= 2'h0;
      hold_half_q  <= 1'b0;
      hold_l1_q    <= 1'b0;
      hold_addr_q  <= '0;
    end
    else
    begin
      resp_valid_q <= 1'b0;
      unique case (state_q)
        DPB_ST_IDLE:
          if (take)
          begin
            resp_valid_q <= 1'b1;
            resp_kind_q  <= cls ? kind : DPB_KIND_BYPASS;
            fwd_addr_q   <= acc_addr;
            fwd_write_q  <= acc_write;
            hold_idx_q   <= hit_idx;
            hold_base_q  <= ent_base_q[hit_idx];
            hold_need_q  <= need;
            hold_half_q  <= hit_half;
            hold_l1_q    <= is_l1;
            hold_addr_q  <= acc_addr;
            if (cls && kind == DPB_KIND_DHIT)
            begin
              resp_data_q <= is_l1 ? {32'h0, ent_data_q[hit_idx][hit_half]}
                                   : {ent_data_q[hit_idx][1], ent_data_q[hit_idx][0]}; // RL1 RL10
            end
            else if (cls && kind == DPB_KIND_DWAIT)
            begin
              resp_valid_q <= 1'b0;
              state_q      <= DPB_ST_WAIT; // RL2
              acc_ready_q  <= 1'b0;
            end
            else
            begin
              fwd_valid_q <= 1'b1; // RL3 RL4
              state_q     <= DPB_ST_FWD;
              acc_ready_q <= 1'b0;
            end
          end
        DPB_ST_WAIT:
          if (w_serve)
          begin
            resp_valid_q <= 1'b1;
            resp_kind_q  <= DPB_KIND_DWAIT;
            resp_data_q  <= hold_l1_q ? {32'h0, ent_data_q[hold_idx_q][hold_half_q]}
                          : {ent_data_q[hold_idx_q][1], ent_data_q[hold_idx_q][0]}; // RL2
            state_q      <= DPB_ST_IDLE;
            acc_ready_q  <= 1'b1;
          end
          else if (w_give)
          begin
            resp_valid_q <= 1'b1;
            resp_kind_q  <= DPB_KIND_AHIT; // RL3
            fwd_valid_q  <= 1'b1;
            fwd_addr_q   <= hold_addr_q;
            state_q      <= DPB_ST_FWD;
          end
        DPB_ST_FWD:
          if (fwd_ready)
          begin
            fwd_valid_q <= 1'b0;
            state_q     <= DPB_ST_IDLE;
            acc_ready_q <= 1'b1;
          end
        default:
        begin
          state_q     <= DPB_ST_IDLE;
          acc_ready_q <= 1'b1;
          fwd_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // apb slave: one wait state, so every access completes on its second access cycle
  assign apb_acc = psel & penable;
  assign mapped  = (paddr == DPB_REG_CTRL) || (paddr == DPB_REG_STAT)
                || (paddr == DPB_REG_MASK) || (paddr == DPB_REG_STATE);
  assign wr_en   = apb_acc & pready_q & pwrite & mapped;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (paddr)
      DPB_REG_CTRL:  rd_mux = 32'(ctrl_q);
      DPB_REG_STAT:  rd_mux = 32'(stat_q);
      DPB_REG_MASK:  rd_mux = 32'(mask_q);
      DPB_REG_STATE: rd_mux = 32'(ent_vld_q) | (32'(alloc_ptr_q) << DPB_ST_PTR_LSB)
                            | (32'(state_q) << DPB_ST_FSM_LSB);
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      ctrl_q    <= DPB_CTRL_RST;
      mask_q    <= DPB_MASK_RST;
    end
    else
    begin
      pready_q  <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~mapped;
      prdata_q  <= (apb_acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
      if (wr_en && paddr == DPB_REG_CTRL)
        ctrl_q <= pwdata[DPB_CTRL_W-1:0];
      if (wr_en && paddr == DPB_REG_MASK)
        mask_q <= pwdata[DPB_EV_W-1:0];
    end
  end

  // sticky status: an event in the clearing cycle survives
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~((wr_en && paddr == DPB_REG_STAT) ? pwdata[DPB_EV_W-1:0] : 6'h00))
              | ev;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  default clocking dpb_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  dhit_serve_a: assert property (cls && is_l1 && kind == DPB_KIND_DHIT |=> // RL1
    resp_valid_q && resp_kind_q == DPB_KIND_DHIT && !fwd_valid_q && acc_ready_q)
    else $error("data hit not served from buffer");
  wait_hold_a: assert property (state_q == DPB_ST_WAIT |-> !acc_ready_q && !fwd_valid_q) // RL2
    else $error("waiting access not held");
  ahit_fwd_a: assert property (cls && kind == DPB_KIND_AHIT |=> // RL3
    fwd_valid_q && fwd_addr_q == $past(acc_addr) && resp_kind_q == DPB_KIND_AHIT)
    else $error("address hit not forwarded");
  collide_later_a: assert property (new_pf_v && pf_valid_q && !pf_ready |=> // RL5
    pf_valid_q && pf_tag_q == $past(new_tag))
    else $error("later prefetch did not win");
  write_inval_a: assert property (take && acc_write && hit_any |=> // RL7
    !ent_pres_q[$past(hit_idx)][$past(hit_half)])
    else $error("write left prefetched data valid");
  fail_nodata_a: assert property (ret_valid && ret_live && !ret_ok |=> // RL8
    !ent_pres_q[$past(ret_slot)][$past(ret_half)] && stat_q[DPB_EV_FAIL])
    else $error("failed return supplied data");
  l2_whole_a: assert property (cls && !is_l1 && hit_any && ent_pres_q[hit_idx] != 2'b11 // RL10
    |=> resp_kind_q != DPB_KIND_DHIT)
    else $error("level-2 served from half a line");
  l2_no_refetch_a: assert property (take && !is_l1 && !alloc && !sched_q |=> // RL12
    $stable(pf_tag_q))
    else $error("re-fetch issued for level-2 access");
  ptr_step_a: assert property (alloc |=> alloc_ptr_q == $past(alloc_ptr_q) + 3'h1 // RL14
    && ent_pend_q[$past(alloc_ptr_q)] == 2'h3)
    else $error("allocation pointer not advanced");
  stream_pair_a: assert property (alloc ##1 !new_pf_v |-> // RL15
    pf_addr_q == $past({gran + 26'h1, 6'h00}) ##1 pf_addr_q == $past({gran + 26'h2, 6'h00}, 2))
    else $error("stream prefetch pair wrong");
  gate_a: assert property (take && !acc_write && !pf_ok |=> resp_kind_q == DPB_KIND_BYPASS // RL16
    && fwd_valid_q)
    else $error("non-prefetchable access classified");
  stale_drop_a: assert property (ret_valid && !ret_live |=> stat_q[DPB_EV_STALE]) // RL13
    else $error("stale return not reported");

  alloc_c: cover property (alloc ##1 sched_q);
  wait_serve_c: cover property (state_q == DPB_ST_WAIT ##[1:20] w_serve);
  stale_c: cover property (ret_valid && !ret_live);
  collide_c: cover property (drop_a_v);

endmodule // dpb_prefetch_buffer

//--- dpb_smc_model.sv
// Purpose: shared_memory_controller model facing the pre-fetch buffer
// Assumes: one clock; a return echoes the issued tag
// Notes:   two holding slots; return delay and forward stalls are random;
//          reads of addresses with bit 20 set come back failed
`timescale 1ns/1ns
module dpb_smc_model
  import dpb_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 fwd_valid_q,
  output logic                      fwd_ready,
  input  wire logic                 pf_valid_q,
  input  wire logic [31:0]          pf_addr_q,
  input  wire logic [DPB_TAG_W-1:0] pf_tag_q,
  output logic                      pf_ready,
  output logic                      ret_valid,
  output logic      [DPB_TAG_W-1:0] ret_tag,
  output logic                      ret_ok,
  output logic      [31:0]          ret_data
);
  logic [DPB_TAG_W+31:0] hold[$];
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold.delete();
      fwd_ready <= 1'b0;
      pf_ready  <= 1'b0;
      ret_valid <= 1'b0;
      ret_tag   <= '0;
      ret_ok    <= 1'b0;
      ret_data  <= 32'h0;
    end
    else
    begin
      fwd_ready <= 1'($urandom_range(0, 1));
      pf_ready  <= 1'b1;
      ret_valid <= 1'b0;
      // idle bus must not look like the last word
      ret_data  <= ~ret_data;
      if (hold.size() != 0 && $urandom_range(0, 3) == 0)
      begin
        ret_valid <= 1'b1;
        ret_tag   <= hold[0][DPB_TAG_W+31:32];
        ret_ok    <= ~hold[0][20];
        ret_data  <= hold[0][31:0] ^ 32'h5A5A0000;
        void'(hold.pop_front());
      end
      if (pf_valid_q && pf_ready)
      begin
        if (hold.size() == 2)
          void'(hold.pop_front());
        hold.push_back({pf_tag_q, pf_addr_q});
      end
    end
  end
endmodule // dpb_smc_model

//--- data_prefetch_buffer_tb_top.sv
// Purpose: self-checking bench of the data pre-fetch buffer
// Assumes: far side returns data = address ^ 32'h5A5A0000, fails reads with address bit 20 set
// Notes:   expected kinds and data come from the stream rules
`timescale 1ns/1ns
module data_prefetch_buffer_tb_top
  import dpb_pkg::*;
();
  logic                 clk_sys, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, acc_addr = 32'h0, prdata_q, fwd_addr_q, pf_addr_q;
  logic [31:0]          ret_data;
  logic                 acc_valid = 1'b0, acc_write = 1'b0, acc_src_l2 = 1'b0;
  logic                 level2_freeze_bit = 1'b0, region_prefetchable_bit = 1'b1;
  logic                 region_cacheable_bit = 1'b1;
  logic [2:0]           level2_size_mode = 3'h1;
  logic                 pready_q, pslverr_q, irq_q, acc_ready_q, resp_valid_q, fwd_valid_q;
  logic                 fwd_write_q, fwd_ready, pf_valid_q, pf_ready, ret_valid, ret_ok;
  logic [63:0]          resp_data_q;
  logic [DPB_TAG_W-1:0] pf_tag_q, ret_tag;
  dpb_kind_t            resp_kind_q;
  int                   err_count, check_count, rets;
  logic [31:0]          pf_log[$];

  dpb_prefetch_buffer DUT (.*);
  dpb_smc_model FAR (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (pf_valid_q && pf_ready)
      pf_log.push_back(pf_addr_q);
    if (ret_valid)
      rets++;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk_sys); while (pready_q !== 1'b1 && ++n < 50);
    if (pready_q !== 1'b1)
      err_count++;
    rd = prdata_q;
    er = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one access; waits for take, then for its response
  task automatic acc(input logic [31:0] a, input logic wr, input logic l2, input logic pf,
                     input dpb_kind_t k, input logic [63:0] d);
    int n;
    @(posedge clk_sys);
    acc_valid               <= 1'b1;
    acc_addr                <= a;
    acc_write               <= wr;
    acc_src_l2              <= l2;
    region_prefetchable_bit <= pf;
    n = 0;
    do @(posedge clk_sys); while (acc_ready_q !== 1'b1 && ++n < 200);
    if (acc_ready_q !== 1'b1)
      err_count++;
    acc_valid <= 1'b0;
    n = 0;
    do @(posedge clk_sys); while (resp_valid_q !== 1'b1 && ++n < 200);
    if (resp_valid_q !== 1'b1)
      err_count++;
    chk("resp kind", 64'(k), 64'(resp_kind_q));
    if (k == DPB_KIND_DHIT)
      chk("resp data", d, resp_data_q);
  endtask

  // waits for the far side to have returned m prefetches in all
  task automatic wait_rets(input int m);
    int n;
    n = 0;
    while (rets < m && n++ < 400)
      @(posedge clk_sys);
    if (rets < m)
      err_count++;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #40000;
    err_count++;
    final_report();
  end

  initial
  begin
    logic [31:0] rd, x, k;
    logic        er;
    x = $urandom(991);
    k = 32'h5A5A0000;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, DPB_REG_CTRL, 32'h0, rd, er);
    chk("ctrl reset", 64'(DPB_CTRL_RST), 64'(rd));
    apb(1'b0, DPB_REG_MASK, 32'h0, rd, er);
    chk("mask reset", 64'(DPB_MASK_RST), 64'(rd));
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk("unmapped error", 64'h1, 64'(er));
    x = 32'h00010000;
    acc(x, 1'b0, 1'b0, 1'b1, DPB_KIND_MISS, 64'h0);
    acc(x, 1'b0, 1'b0, 1'b1, DPB_KIND_MISS, 64'h0);
    wait_rets(2);
    chk("first prefetch", 64'(x + 32'h40), 64'(pf_log[0]));
    chk("second prefetch", 64'(x + 32'h80), 64'(pf_log[1]));
    acc(x + 32'h40, 1'b0, 1'b0, 1'b1, DPB_KIND_DHIT, {32'h0, (x + 32'h40) ^ k});
    acc(x + 32'h40, 1'b0, 1'b1, 1'b1, DPB_KIND_DHIT,
        {(x + 32'h80) ^ k, (x + 32'h40) ^ k});
    level2_freeze_bit <= 1'b1;
    // frozen level-2 is served like a level-1 half
    acc(x + 32'h80, 1'b0, 1'b1, 1'b1, DPB_KIND_DHIT, {32'h0, (x + 32'h80) ^ k});
    level2_freeze_bit <= 1'b0;
    level2_size_mode  <= 3'h0;
    acc(x + 32'h80, 1'b0, 1'b1, 1'b1, DPB_KIND_DHIT, {32'h0, (x + 32'h80) ^ k});
    level2_size_mode  <= 3'h1;
    acc(x + 32'h40, 1'b1, 1'b0, 1'b1, DPB_KIND_BYPASS, 64'h0);
    acc(x + 32'h40, 1'b0, 1'b0, 1'b1, DPB_KIND_AHIT, 64'h0);
    acc({8'hF0, 24'($urandom)}, 1'b0, 1'b0, 1'b0, DPB_KIND_BYPASS, 64'h0);
    // second stream: the far side fails both of its prefetches
    x = 32'h00110000;
    acc(x, 1'b0, 1'b0, 1'b1, DPB_KIND_MISS, 64'h0);
    acc(x, 1'b0, 1'b0, 1'b1, DPB_KIND_MISS, 64'h0);
    wait_rets(4);
    acc(x + 32'h40, 1'b0, 1'b0, 1'b1, DPB_KIND_AHIT, 64'h0);
    wait_rets(5);
    chk("refetch", 64'(x + 32'h80), 64'(pf_log[4]));
    apb(1'b1, DPB_REG_MASK, 32'h1 << DPB_EV_MISS, rd, er);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", 64'h1, 64'(irq_q));
    apb(1'b0, DPB_REG_STAT, 32'h0, rd, er);
    chk("miss status", 64'h1, 64'(rd[DPB_EV_MISS]));
    chk("fail status", 64'h1, 64'(rd[DPB_EV_FAIL]));
    apb(1'b1, DPB_REG_STAT, 32'h1 << DPB_EV_MISS, rd, er);
    apb(1'b0, DPB_REG_STAT, 32'h0, rd, er);
    chk("miss cleared", 64'h0, 64'(rd[DPB_EV_MISS]));
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 64'h0, 64'(irq_q));
    final_report();
  end
endmodule // data_prefetch_buffer_tb_top
